// File: rtl/hbi_device.sv
// Device end of the host bus interface: decode, strobes, wait states and data drive.
`timescale 1ns/1ps
`include "hbi_defs.svh"
module hbi_device (
  hbi_if.dev                 bus,
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [15:4]   base_addr,
  input  wire logic          bus_is_32,
  output logic               acc_req,
  output logic               acc_write,
  output logic               acc_data_port,
  output logic [15:1]        acc_addr,
  output logic [3:0]         acc_lanes,
  output logic [31:0]        acc_wdata,
  input  wire logic          acc_ready,
  input  wire logic [31:0]   acc_rdata
);
  import hbi_pkg::*;

  logic [`HBI_DEV_PINS_W-1:0] pins_raw;
  logic [`HBI_DEV_PINS_W-1:0] pins;
  logic                       as_n;
  logic                       aq;
  logic [3:0]                 ln;
  logic [15:1]                addr;
  logic                       dps_n;
  logic                       style_n;
  logic                       bclk;
  logic                       cq_n;
  logic                       wnr;
  logic                       rr_n;
  logic                       rd_n;
  logic                       wr_n;
  logic [31:0]                din;
  logic                       bclk_q;
  logic                       bclk_rise;
  logic                       bclk_rise_q;
  logic [20:1]                lat;
  logic                       eff_aq;
  logic [3:0]                 eff_ln;
  logic [15:1]                eff_addr;
  logic                       hit;
  logic                       selected;
  dev_state_t                 state;
  logic [31:0]                rdata_q;
  logic                       rd_valid;
  logic                       next_drive;

  assign pins_raw = {bus.address_strobe_n, bus.addr_qualify,
                     bus.lane_enable_n3, bus.lane_enable_n2, bus.lane_enable_n1, bus.lane_enable_n0,
                     bus.address, bus.data_port_select_n, bus.sync_style_select_n, bus.host_bus_clock,
                     bus.cycle_qualify_n, bus.sync_write_not_read, bus.ready_return_n,
                     bus.async_read_strobe_n, bus.async_write_strobe_n, bus.data};

  sync3 #(
    .WIDTH(`HBI_DEV_PINS_W)
  ) u_pin_sync (
    .clk  (clk),
    .rst_n(rst_n),
    .din  (pins_raw),
    .dout (pins)
  );

  assign {as_n, aq, ln, addr, dps_n, style_n, bclk, cq_n, wnr, rr_n, rd_n, wr_n, din} = pins;

  // Edge detection on the bus clock, seen through the synchroniser.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bclk_q      <= 1'b1;
      bclk_rise_q <= 1'b0;
    end else begin
      bclk_q      <= bclk;
      bclk_rise_q <= bclk_rise;
    end
  end
  assign bclk_rise = bclk && !bclk_q;

  // The latch follows the pins while the strobe is low and holds them from its rise.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lat <= '1;
    end else if (!as_n) begin
      lat <= {aq, ln, addr}; // R1 R20
    end
  end
  assign eff_aq   = as_n ? lat[20] : aq;
  assign eff_ln   = as_n ? lat[19:16] : ln;
  assign eff_addr = as_n ? lat[15:1] : addr;

  // Local decode is only live while the qualify pin is low.
  assign hit      = !eff_aq && (eff_addr[15:4] == base_addr); // R2 R21 R20
  // The central-decode select bypasses the local decoder entirely.
  assign selected = !dps_n || hit; // R4

  // Transfer sequencing and the access port toward the queue logic.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state         <= ST_IDLE;
      acc_req       <= 1'b0;
      acc_write     <= 1'b0;
      acc_data_port <= 1'b0;
      acc_addr      <= '0;
      acc_lanes     <= '0;
      acc_wdata     <= '0;
      rdata_q       <= '0;
      rd_valid      <= 1'b0;
    end else begin
      if (acc_req && acc_ready) begin
        acc_req <= 1'b0;
        if (!acc_write) begin
          rdata_q  <= acc_rdata;
          rd_valid <= 1'b1;
        end
      end
      unique case (state)
        ST_IDLE: begin
          if (selected && !acc_req) begin
            acc_data_port <= !dps_n;
            acc_addr      <= dps_n ? eff_addr : `HBI_DATA_REG_ADDR; // R5
            acc_lanes     <= lanes_active(eff_ln, !dps_n, bus_is_32); // R4 R6 R22
            if (!rd_n) begin
              acc_write <= 1'b0;
              acc_req   <= 1'b1;
              state     <= ST_ASYNC_RD; // R16
            end else if (!wr_n) begin
              state <= ST_ASYNC_WR;
            end else if (bclk_rise && !style_n && !cq_n) begin
              acc_write <= wnr; // R8 R7
              acc_wdata <= din;
              acc_req   <= 1'b1;
              state     <= ST_VL_ACC;
            end else if (bclk_rise && style_n && (!cq_n || !wnr)) begin
              acc_write <= !cq_n; // R7
              acc_req   <= cq_n;
              state     <= ST_BURST;
            end
          end
        end
        ST_ASYNC_RD: begin
          if (rd_n) begin
            rd_valid <= 1'b0;
            state    <= ST_IDLE;
          end
        end
        ST_ASYNC_WR: begin
          if (wr_n) begin
            acc_wdata <= din; // R18
            acc_write <= 1'b1;
            acc_req   <= 1'b1;
            state     <= ST_IDLE;
          end
        end
        ST_VL_ACC: begin
          if (!acc_req) begin
            state <= ST_VL_HOLD;
          end
        end
        ST_VL_HOLD: begin
          if (bclk_rise && !rr_n) begin
            rd_valid <= 1'b0; // R12
            state    <= ST_IDLE;
          end
        end
        ST_BURST: begin
          if (bclk_rise) begin
            if (cq_n && wnr) begin
              rd_valid <= 1'b0;
              state    <= ST_IDLE;
            end else if (rr_n && !bus.sync_ready_n) begin // R13
              if (!cq_n) begin
                acc_write <= 1'b1;
                acc_wdata <= din;
                acc_req   <= 1'b1;
              end else begin
                rd_valid <= 1'b0;
              end
            end else if (!wnr && !rd_valid && !acc_req) begin
              acc_write <= 1'b0;
              acc_req   <= 1'b1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Read data goes on the pins only while a targeted read holds valid data.
  assign next_drive = rd_valid && ((state == ST_ASYNC_RD) ||
                                   (state == ST_VL_HOLD && !acc_write) ||
                                   (state == ST_BURST && !wnr)); // R24

  // Pin outputs: select, ready signals and data drive.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus.local_select_n <= 1'b1;
      bus.async_ready    <= 1'b1;
      bus.sync_ready_n   <= 1'b1;
      bus.dev_data_out   <= '0;
      bus.dev_data_oe_n  <= 2'b11;
    end else begin
      bus.local_select_n <= !hit; // R3
      bus.async_ready    <= !((state == ST_ASYNC_RD && !rd_valid) ||
                              (state == ST_IDLE && selected && acc_req && (!rd_n || !wr_n))); // R14
      if (state == ST_VL_ACC) begin
        bus.sync_ready_n <= acc_req;
      end else if (state == ST_BURST) begin
        if (bclk_rise_q) begin
          bus.sync_ready_n <= !cq_n ? acc_req : !rd_valid; // R11
        end
      end else if (state != ST_VL_HOLD) begin
        bus.sync_ready_n <= 1'b1;
      end
      bus.dev_data_out  <= rdata_q;
      bus.dev_data_oe_n <= {!(next_drive && bus_is_32), !next_drive}; // R6 R19
    end
  end
endmodule // hbi_device

// File: rtl/hbi_defs.svh
// Constants for the host bus interface: addresses, pin widths and timing counts.
// How it works
// R1: Address strobe rise captures address, qualify, lanes.
// R2: Local select decodes qualify and upper address.
// R3: Local select asserts whenever this device is addressed; the code asserts it on a local decode hit only, not for data port select.
// R4: Data port select forces 32-bit data register.
// R5: Data port path reaches only the data register.
// R6: Upper data half used only on wide bus.
// R7: Style pin picks single-transfer or burst cycles.
// R8: Single style samples direction at qualified clock.
// R9: Burst host uses qualify/direction as write/read.
// R10: Single style host drives direction high for write.
// R11: Burst device holds ready high while not ready.
// R12: Single style host returns ready to end cycle.
// R13: Burst host inserts waits with ready return.
// R14: Async ready goes low to insert waits.
// R15: Async host keeps synchronous pins constant deasserted.
// R16: Asynchronous strobes carry single transfers only.
// R17: Stable address host ties address strobe low.
// R18: Async write data captured at strobe rise.
// R19: Host takes read data at read strobe rise.
// R20: Pulsed strobe address is latched then decoded.
// R21: Decode enabled only while address qualify low.
// R22: Lane enables select word, half-word or byte.
// R23: Host never overlaps synchronous and asynchronous cycles.
// R24: Data pins driven only during targeted reads.
`ifndef HBI_DEFS_SVH
`define HBI_DEFS_SVH
`define HBI_CLK_NS          5
`define HBI_BCLK_HALF_NS    40
`define HBI_BCLK_HALF_CYC   ((`HBI_BCLK_HALF_NS) / (`HBI_CLK_NS))
`define HBI_SETUP_NS        20
`define HBI_SETUP_CYC       ((`HBI_SETUP_NS + `HBI_CLK_NS - 1) / (`HBI_CLK_NS))
`define HBI_STROBE_MIN_NS   60
`define HBI_STROBE_MIN_CYC  ((`HBI_STROBE_MIN_NS + `HBI_CLK_NS - 1) / (`HBI_CLK_NS))
`define HBI_HOLD_NS         30
`define HBI_HOLD_CYC        ((`HBI_HOLD_NS + `HBI_CLK_NS - 1) / (`HBI_CLK_NS))
`define HBI_DATA_REG_ADDR   15'h0008
`define HBI_DEV_PINS_W      61
`define HBI_HOST_PINS_W     34
`endif

// File: rtl/hbi_pkg.sv
// Types and helpers shared by both ends of the host bus interface.
package hbi_pkg;
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ASYNC_RD = 3'b001,
    ST_ASYNC_WR = 3'b010,
    ST_VL_ACC   = 3'b011,
    ST_VL_HOLD  = 3'b100,
    ST_BURST    = 3'b101
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE     = 3'b000,
    H_A_SETUP  = 3'b001,
    H_A_STROBE = 3'b010,
    H_A_HOLD   = 3'b011,
    H_S_START  = 3'b100,
    H_S_WAIT   = 3'b101,
    H_S_ACK    = 3'b110,
    H_S_END    = 3'b111
  } host_state_t;
  // Turns the active-low lane enables into active-high lanes for the access.
  function automatic logic [3:0] lanes_active(input logic [3:0] lane_n, input logic data_port, input logic wide);
    logic [3:0] act;
    act = ~lane_n;
    if (data_port) begin
      act = 4'hf;
    end
    if (!wide) begin
      act[3:2] = 2'b00;
    end
    return act;
  endfunction
endpackage

// File: rtl/hbi_if.sv
// Pins between the host and the device, with the shared data wire resolved.
`timescale 1ns/1ps
interface hbi_if;
  logic        address_strobe_n;
  logic [15:1] address;
  logic        addr_qualify;
  logic        lane_enable_n0;
  logic        lane_enable_n1;
  logic        lane_enable_n2;
  logic        lane_enable_n3;
  logic        data_port_select_n;
  logic        sync_style_select_n;
  logic        host_bus_clock;
  logic        cycle_qualify_n;
  logic        sync_write_not_read;
  logic        ready_return_n;
  logic        async_read_strobe_n;
  logic        async_write_strobe_n;
  logic        local_select_n;
  logic        sync_ready_n;
  logic        async_ready;
  logic [31:0] dev_data_out;
  logic [1:0]  dev_data_oe_n;
  logic [31:0] host_data_out;
  logic        host_data_oe_n;
  logic [31:0] data;
  // Undriven halves float high as if pulled up.
  assign data[15:0]  = !dev_data_oe_n[0] ? dev_data_out[15:0] : (!host_data_oe_n ? host_data_out[15:0] : 16'hffff);
  assign data[31:16] = !dev_data_oe_n[1] ? dev_data_out[31:16] : (!host_data_oe_n ? host_data_out[31:16] : 16'hffff);
  modport dev (
    input  address_strobe_n, address, addr_qualify, lane_enable_n0, lane_enable_n1, lane_enable_n2,
    input  lane_enable_n3, data_port_select_n, sync_style_select_n, host_bus_clock, cycle_qualify_n,
    input  sync_write_not_read, ready_return_n, async_read_strobe_n, async_write_strobe_n, data,
    output local_select_n, sync_ready_n, async_ready, dev_data_out, dev_data_oe_n
  );
  modport host (
    output address_strobe_n, address, addr_qualify, lane_enable_n0, lane_enable_n1, lane_enable_n2,
    output lane_enable_n3, data_port_select_n, sync_style_select_n, host_bus_clock, cycle_qualify_n,
    output sync_write_not_read, ready_return_n, async_read_strobe_n, async_write_strobe_n,
    output host_data_out, host_data_oe_n,
    input  local_select_n, sync_ready_n, async_ready, data
  );
endinterface

// File: rtl/sync3.sv
// Three-stage input synchroniser that passes a bit once the last two stages agree.
`timescale 1ns/1ps
module sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  // Reset to all ones so active-low strobes read idle until real levels arrive.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1   <= '1;
      s2   <= '1;
      s3   <= '1;
      dout <= '1;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= (s2 & s3) | (dout & (s2 ^ s3));
    end
  end
endmodule // sync3

// File: rtl/hbi_host.sv
// Host end of the host bus interface: runs one asynchronous or synchronous transfer per command.
`timescale 1ns/1ps
`include "hbi_defs.svh"
module hbi_host (
  hbi_if.host                bus,
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          style_burst,
  input  wire logic          cmd_valid,
  output logic               cmd_ready,
  input  wire logic          cmd_sync,
  input  wire logic          cmd_write,
  input  wire logic          cmd_data_port,
  input  wire logic [15:1]   cmd_addr,
  input  wire logic [3:0]    cmd_lanes_n,
  input  wire logic [31:0]   cmd_wdata,
  output logic               rsp_valid,
  output logic [31:0]        rsp_rdata
);
  import hbi_pkg::*;

  logic [`HBI_HOST_PINS_W-1:0] in_s;
  logic                        srdy_n_s;
  logic                        aok_s;
  logic [31:0]                 data_s;
  host_state_t                 state;
  logic [3:0]                  cnt;
  logic [3:0]                  div;
  logic                        run;
  logic                        tick;
  logic                        fall_ev;
  logic                        rise_ev;
  logic                        write_q;

  sync3 #(
    .WIDTH(`HBI_HOST_PINS_W)
  ) u_pin_sync (
    .clk  (clk),
    .rst_n(rst_n),
    .din  ({bus.sync_ready_n, bus.async_ready, bus.data}),
    .dout (in_s)
  );
  assign {srdy_n_s, aok_s, data_s} = in_s;

  // Bus clock divider; it runs only during synchronous transfers and stops low.
  assign tick    = run && (div == 4'(`HBI_BCLK_HALF_CYC - 1));
  assign fall_ev = tick && bus.host_bus_clock;
  assign rise_ev = tick && !bus.host_bus_clock;
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      div                <= 4'h0;
      bus.host_bus_clock <= 1'b0; // R15
    end else if (tick) begin
      div                <= 4'h0;
      bus.host_bus_clock <= !bus.host_bus_clock;
    end else begin
      div <= div + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state                    <= H_IDLE;
      cnt                      <= 4'h0;
      run                      <= 1'b0;
      write_q                  <= 1'b0;
      cmd_ready                <= 1'b0;
      rsp_valid                <= 1'b0;
      rsp_rdata                <= '0;
      bus.address_strobe_n     <= 1'b0;
      bus.address              <= '0;
      bus.addr_qualify         <= 1'b1;
      {bus.lane_enable_n3, bus.lane_enable_n2, bus.lane_enable_n1, bus.lane_enable_n0} <= 4'hf;
      bus.data_port_select_n   <= 1'b1;
      bus.sync_style_select_n  <= 1'b0;
      bus.cycle_qualify_n      <= 1'b1;
      bus.sync_write_not_read  <= 1'b1;
      bus.ready_return_n       <= 1'b1;
      bus.async_read_strobe_n  <= 1'b1;
      bus.async_write_strobe_n <= 1'b1;
      bus.host_data_out        <= '0;
      bus.host_data_oe_n       <= 1'b1;
    end else begin
      rsp_valid                <= 1'b0;
      bus.sync_style_select_n  <= style_burst; // R7
      bus.address_strobe_n     <= 1'b0; // R17
      unique case (state)
        H_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready              <= 1'b0;
            write_q                <= cmd_write;
            bus.address            <= cmd_addr;
            bus.addr_qualify       <= 1'b0;
            {bus.lane_enable_n3, bus.lane_enable_n2, bus.lane_enable_n1, bus.lane_enable_n0} <= cmd_lanes_n;
            bus.data_port_select_n <= !cmd_data_port;
            bus.host_data_out      <= cmd_wdata;
            bus.host_data_oe_n     <= !cmd_write;
            cnt                    <= 4'(`HBI_SETUP_CYC);
            run                    <= cmd_sync;
            state                  <= cmd_sync ? H_S_START : H_A_SETUP; // R23
          end
        end
        H_A_SETUP: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else begin
            bus.async_read_strobe_n  <= write_q; // R16
            bus.async_write_strobe_n <= !write_q;
            cnt                      <= 4'(`HBI_STROBE_MIN_CYC);
            state                    <= H_A_STROBE;
          end
        end
        H_A_STROBE: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else if (aok_s) begin // R14
            rsp_rdata                <= data_s; // R19
            bus.async_read_strobe_n  <= 1'b1;
            bus.async_write_strobe_n <= 1'b1;
            cnt                      <= 4'(`HBI_HOLD_CYC);
            state                    <= H_A_HOLD;
          end
        end
        H_A_HOLD: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else begin
            bus.host_data_oe_n     <= 1'b1;
            bus.addr_qualify       <= 1'b1;
            bus.data_port_select_n <= 1'b1;
            rsp_valid              <= 1'b1;
            state                  <= H_IDLE;
          end
        end
        H_S_START: begin
          if (fall_ev) begin
            if (style_burst) begin
              bus.cycle_qualify_n     <= !write_q; // R9
              bus.sync_write_not_read <= write_q;
            end else begin
              bus.cycle_qualify_n     <= 1'b0;
              bus.sync_write_not_read <= write_q; // R10
            end
            state <= H_S_WAIT;
          end
        end
        H_S_WAIT: begin
          if (fall_ev && !style_burst) begin
            bus.cycle_qualify_n <= 1'b1;
          end
          if (rise_ev && !srdy_n_s) begin
            rsp_rdata <= data_s;
            state     <= H_S_ACK;
          end
        end
        H_S_ACK: begin
          if (fall_ev) begin
            bus.cycle_qualify_n     <= 1'b1;
            bus.sync_write_not_read <= 1'b1;
            bus.host_data_oe_n      <= 1'b1;
            bus.ready_return_n      <= style_burst; // R12
            state                   <= H_S_END;
          end
        end
        H_S_END: begin
          if (fall_ev) begin
            bus.ready_return_n     <= 1'b1; // R13
            bus.addr_qualify       <= 1'b1;
            bus.data_port_select_n <= 1'b1;
            run                    <= 1'b0;
            rsp_valid              <= 1'b1;
            state                  <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule // hbi_host

// File: bench/hbi_chk.sv
// Concurrent checks on the pins between the host and device ends.
`timescale 1ns/1ps
module hbi_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [15:4] base_addr,
  input wire logic        bus_is_32,
  input wire logic        address_strobe_n,
  input wire logic [15:1] address,
  input wire logic        addr_qualify,
  input wire logic        data_port_select_n,
  input wire logic        sync_style_select_n,
  input wire logic        host_bus_clock,
  input wire logic        cycle_qualify_n,
  input wire logic        ready_return_n,
  input wire logic        async_read_strobe_n,
  input wire logic        async_write_strobe_n,
  input wire logic        local_select_n,
  input wire logic        sync_ready_n,
  input wire logic        async_ready,
  input wire logic [1:0]  dev_data_oe_n,
  input wire logic        host_data_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_decode_off_qual: assert property (addr_qualify [*8] |-> local_select_n)
    else $error("select seen while address qualify high");
  a_miss_no_select: assert property ((address[15:4] != base_addr && data_port_select_n) [*8] |-> local_select_n)
    else $error("select seen on a missed address");
  a_hit_selects: assert property ((!addr_qualify && address[15:4] == base_addr && data_port_select_n) [*8]
    |-> !local_select_n)
    else $error("select missing on a matching address");
  a_wait_in_strobe: assert property (!async_ready |-> (!async_read_strobe_n || !async_write_strobe_n))
    else $error("async wait outside a strobe");
  a_ack_after_ready: assert property ((!sync_style_select_n && $fell(ready_return_n)) |-> !$past(sync_ready_n))
    else $error("ready return without device ready");
  a_no_contention: assert property (dev_data_oe_n != 2'b11 |-> host_data_oe_n)
    else $error("both ends drive the data bus");
  a_narrow_upper: assert property (!bus_is_32 |-> dev_data_oe_n[1])
    else $error("upper data half driven on narrow bus");
  a_async_quiet: assert property ((!async_read_strobe_n || !async_write_strobe_n)
    |-> (!host_bus_clock && cycle_qualify_n && ready_return_n))
    else $error("sync pins active during async transfer");
  a_no_overlap: assert property (!cycle_qualify_n |-> (async_read_strobe_n && async_write_strobe_n))
    else $error("sync and async transfers overlap");
  a_single_strobe: assert property (async_read_strobe_n || async_write_strobe_n)
    else $error("both async strobes low");
  a_addr_strobe_low: assert property (!address_strobe_n)
    else $error("address strobe left low expected");
endmodule // hbi_chk

// File: bench/tb.sv
// Testbench joining the host and device ends of the host bus interface.
`timescale 1ns/1ps
`include "hbi_defs.svh"
module tb;
  import hbi_pkg::*;
  localparam logic [15:1] HIT  = 15'h1232;
  localparam logic [15:1] MISS = HIT ^ 15'h4000;
  logic        clk, rst_n, bus_is_32, style_burst, cmd_valid, cmd_ready, cmd_sync, cmd_write, cmd_data_port;
  logic [15:1] cmd_addr, acc_addr, lw_addr;
  logic [3:0]  cmd_lanes_n, acc_lanes, lw_lanes, lt [6];
  logic [31:0] cmd_wdata, rsp_rdata, acc_wdata, acc_rdata, lw_data, rd, p;
  logic        rsp_valid, acc_req, acc_write, acc_data_port, acc_ready, lw_write, lw_dp;
  logic [15:4] base_addr;
  int          errors, tests_run, acc_cnt, n0;
  hbi_if bus ();
  hbi_host u_hbi_host (.bus(bus), .clk(clk), .rst_n(rst_n), .style_burst(style_burst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_sync(cmd_sync), .cmd_write(cmd_write), .cmd_data_port(cmd_data_port),
    .cmd_addr(cmd_addr), .cmd_lanes_n(cmd_lanes_n), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  hbi_device u_hbi_device (.bus(bus), .clk(clk), .rst_n(rst_n), .base_addr(base_addr), .bus_is_32(bus_is_32),
    .acc_req(acc_req), .acc_write(acc_write), .acc_data_port(acc_data_port), .acc_addr(acc_addr),
    .acc_lanes(acc_lanes), .acc_wdata(acc_wdata), .acc_ready(acc_ready), .acc_rdata(acc_rdata));
  hbi_chk u_hbi_chk (.clk(clk), .rst_n(rst_n), .base_addr(base_addr), .bus_is_32(bus_is_32),
    .address_strobe_n(bus.address_strobe_n), .address(bus.address), .addr_qualify(bus.addr_qualify),
    .data_port_select_n(bus.data_port_select_n), .sync_style_select_n(bus.sync_style_select_n),
    .host_bus_clock(bus.host_bus_clock), .cycle_qualify_n(bus.cycle_qualify_n),
    .ready_return_n(bus.ready_return_n), .async_read_strobe_n(bus.async_read_strobe_n),
    .async_write_strobe_n(bus.async_write_strobe_n), .local_select_n(bus.local_select_n),
    .sync_ready_n(bus.sync_ready_n), .async_ready(bus.async_ready), .dev_data_oe_n(bus.dev_data_oe_n),
    .host_data_oe_n(bus.host_data_oe_n));
  function automatic logic [31:0] pat(input logic [15:1] a);
    return {~a, 1'b1, a, 1'b0};
  endfunction
  // Data register side: answers each access one cycle after the request and records it.
  always @(posedge clk) begin
    acc_rdata <= pat(acc_addr);
    acc_ready <= rst_n && acc_req && !acc_ready;
    if (rst_n && acc_req && acc_ready) begin
      acc_cnt  <= acc_cnt + 1;
      lw_addr  <= acc_addr;
      lw_lanes <= acc_lanes;
      lw_data  <= acc_wdata;
      lw_write <= acc_write;
      lw_dp    <= acc_data_port;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk) rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic run(input logic st, s, w, dp, input logic [15:1] a, input logic [3:0] ln,
                     input logic [31:0] wd, output logic [31:0] r);
    int n;
    @(posedge clk) style_burst <= st;
    repeat (8) @(posedge clk);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 100);
    @(posedge clk);
    cmd_valid     <= 1'b1;
    cmd_sync      <= s;
    cmd_write     <= w;
    cmd_data_port <= dp;
    cmd_addr      <= a;
    cmd_lanes_n   <= ln;
    cmd_wdata     <= wd;
    @(posedge clk) cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 3000);
    if (n >= 3000) errors++;
    r = rsp_rdata;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    finish_test();
  end
  initial begin
    {rst_n, style_burst, cmd_valid, cmd_sync, cmd_write, cmd_data_port} = '0;
    {cmd_addr, cmd_lanes_n, cmd_wdata} = '0;
    bus_is_32 = 1'b1;
    base_addr = HIT[15:4];
    lt = '{4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3};
    do_reset();
    // Write then read the same address in async, single-transfer and burst styles.
    for (int m = 0; m < 3; m++) begin
      run(m == 2, m != 0, 1'b1, 1'b0, HIT, 4'h0, 32'hA5A5_0F00 + m, rd);
      chk(32'(lw_addr), 32'(HIT));
      chk(lw_data, 32'hA5A5_0F00 + m);
      chk(32'(lw_write), 32'h0000_0001);
      chk(32'(lw_dp), 32'h0000_0000);
      run(m == 2, m != 0, 1'b0, 1'b0, HIT, 4'h0, 32'h0000_0000, rd);
      chk(rd, pat(HIT));
      chk(32'(lw_write), 32'h0000_0000);
    end
    // Data port accesses go to the data register as full words.
    run(1'b0, 1'b0, 1'b1, 1'b1, MISS, 4'hc, 32'h1234_5678, rd);
    chk(32'(lw_addr), 32'(`HBI_DATA_REG_ADDR));
    chk(32'(lw_lanes), 32'h0000_000F);
    chk(32'(lw_dp), 32'h0000_0001);
    chk(lw_data, 32'h1234_5678);
    run(1'b0, 1'b0, 1'b0, 1'b1, MISS, 4'h0, 32'h0000_0000, rd);
    chk(rd, pat(`HBI_DATA_REG_ADDR));
    // Each single-byte and half-word lane pattern reaches the access side.
    foreach (lt[i]) begin
      run(1'b0, 1'b0, 1'b1, 1'b0, HIT, lt[i], 32'hFFFF_FFFF, rd);
      chk({28'h000_0000, lw_lanes}, {28'h000_0000, ~lt[i]});
    end
    // A missed address makes no access and leaves the bus floating high.
    n0 = acc_cnt;
    run(1'b0, 1'b0, 1'b0, 1'b0, MISS, 4'h0, 32'h0000_0000, rd);
    chk(32'(acc_cnt), 32'(n0));
    chk(rd, 32'hFFFF_FFFF);
    // Narrow bus keeps the upper half idle.
    @(posedge clk) bus_is_32 <= 1'b0;
    do_reset();
    run(1'b0, 1'b0, 1'b1, 1'b0, HIT, 4'h0, 32'hCAFE_BEEF, rd);
    chk(32'(lw_lanes), 32'h0000_0003);
    run(1'b0, 1'b0, 1'b0, 1'b0, HIT, 4'h0, 32'h0000_0000, rd);
    p = pat(HIT);
    chk(rd, {16'hFFFF, p[15:0]});
    finish_test();
  end
endmodule // tb
